/* spd_pkg.sv */
// ==========================================================
// shared constants of the serial ping-pong dma block
package spd_pkg;

  localparam int REG_AW = 16;
  localparam int REG_DW = 32;

  // ==========================================================
  // register byte addresses
  localparam logic [15:0] OFS_FLAGS = 16'ha808;
  localparam logic [15:0] OFS_MODE = 16'hc854;
  localparam logic [15:0] OFS_TX_BEG_A = 16'hc800;
  localparam logic [15:0] OFS_TX_BEG_B = 16'hc804;
  localparam logic [15:0] OFS_TX_END_A = 16'hc808;
  localparam logic [15:0] OFS_TX_END_B = 16'hc80c;
  localparam logic [15:0] OFS_RX_BEG_A = 16'hc810;
  localparam logic [15:0] OFS_RX_BEG_B = 16'hc814;
  localparam logic [15:0] OFS_RX_END_A = 16'hc818;
  localparam logic [15:0] OFS_RX_END_B = 16'hc81c;
  localparam logic [15:0] OFS_TX_CNT = 16'hc820;
  localparam logic [15:0] OFS_RX_CNT_A = 16'hc824;
  localparam logic [15:0] OFS_RX_CNT_B = 16'hc828;
  localparam logic [15:0] OFS_RX_ERR_A = 16'hc82c;
  localparam logic [15:0] OFS_RX_ERR_B = 16'hc830;
  localparam logic [15:0] OFS_DMA_CTRL = 16'hc834;
  localparam logic [15:0] OFS_DMA_STAT = 16'hc838;

  // ==========================================================
  // reset values
  localparam logic [14:0] FLAGS_RST = 15'h0000;
  localparam logic [1:0] MODE_RST = 2'h0;

  // ==========================================================
  // pending flag bit positions
  localparam int FLG_PAR_ERR = 14;
  localparam int FLG_FRM_ERR = 13;
  localparam int FLG_TX_ULD_B = 12;
  localparam int FLG_TX_ULD_A = 11;
  localparam int FLG_RX_ULD_B = 10;
  localparam int FLG_RX_ULD_A = 9;
  localparam int FLG_NACK = 8;
  localparam int FLG_CMD_DONE = 7;
  localparam int FLG_I2C_TX_DONE = 6;
  localparam int FLG_I2C_RX_DONE = 5;
  localparam int FLG_TX_UNDERRUN = 4;
  localparam int FLG_RX_OVERRUN = 3;
  localparam int FLG_TX_IDLE = 2;
  localparam int FLG_TX_FREE = 1;
  localparam int FLG_RX_VALID = 0;

  // ==========================================================
  // channel control bits (write one to act)
  localparam int CTL_RX_LOAD_A = 0;
  localparam int CTL_RX_LOAD_B = 1;
  localparam int CTL_TX_LOAD_A = 2;
  localparam int CTL_TX_LOAD_B = 3;
  localparam int CTL_RX_RESET = 4;
  localparam int CTL_TX_RESET = 5;

  // receive error register: offset low, valid flag here
  localparam int ERR_VALID_BIT = 16;

  // ==========================================================
  // controller modes
  localparam logic [1:0] MODE_DISABLED = 2'h0;
  localparam logic [1:0] MODE_UART = 2'h1;
  localparam logic [1:0] MODE_SPI = 2'h2;
  localparam logic [1:0] MODE_I2C = 2'h3;

  typedef enum logic [1:0] {
    BUF_IDLE = 2'b00,
    BUF_PENDING = 2'b01,
    BUF_ACTIVE = 2'b11
  } spd_buf_e;

endpackage : spd_pkg

/* spd_pingpong.sv */
`timescale 1ns/1ns
// ==========================================================
// buffer a/b state tracker of one channel
module spd_pingpong (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic chan_reset,
  input wire logic load_a,
  input wire logic load_b,
  input wire logic unload_a,
  input wire logic unload_b,
  output spd_pkg::spd_buf_e state_a,
  output spd_pkg::spd_buf_e state_b,
  output logic promote
);
  import spd_pkg::*;

  spd_buf_e next_a;
  spd_buf_e next_b;

  always_comb begin
    next_a = state_a;
    next_b = state_b;
    if (unload_a && state_a != BUF_IDLE) begin // [RULE_03] [RULE_13]
      next_a = BUF_IDLE;
    end
    if (unload_b && state_b != BUF_IDLE) begin // [RULE_03] [RULE_13]
      next_b = BUF_IDLE;
    end
    if (load_a && state_a == BUF_IDLE) begin // [RULE_07]
      next_a = (next_b == BUF_ACTIVE) ? BUF_PENDING : BUF_ACTIVE;
    end
    if (load_b && state_b == BUF_IDLE) begin // [RULE_07]
      next_b = (next_a == BUF_ACTIVE) ? BUF_PENDING : BUF_ACTIVE;
    end
    if (next_a == BUF_PENDING && next_b != BUF_ACTIVE) begin // [RULE_01] [RULE_22]
      next_a = BUF_ACTIVE;
    end
    if (next_b == BUF_PENDING && next_a != BUF_ACTIVE) begin // [RULE_01] [RULE_22]
      next_b = BUF_ACTIVE;
    end
  end

  // a pending buffer taking over from the one just unloaded
  assign promote = (state_a == BUF_PENDING && next_a == BUF_ACTIVE)
                || (state_b == BUF_PENDING && next_b == BUF_ACTIVE);

  always_ff @(posedge clk_sys) begin
    if (rst || chan_reset) begin // [RULE_04]
      state_a <= BUF_IDLE;
      state_b <= BUF_IDLE;
    end else begin
      state_a <= next_a;
      state_b <= next_b;
    end
  end

endmodule : spd_pingpong

/* spd_dma_top.sv */
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
// Notes on behaviour
// RULE_01: each channel has buffers a and b and alternates between them by itself.
// RULE_02: tx moves memory to tx fifo, rx moves rx fifo to memory, without stalling.
// RULE_03: each buffer is idle, pending or active; unloading returns it to idle.
// RULE_04: channel reset bit idles both buffers and clears the channel counts.
// RULE_05: buffers span start to end address, end byte included.
// RULE_06: software keeps every buffer inside on-chip ram.
// RULE_07: load bit makes a buffer pending, or active when none is in use.
// RULE_08: end address may change while loaded and applies at once.
// RULE_09: count is offset of next byte and steps by one per byte.
// RULE_10: tx shares one count; rx has one count per buffer.
// RULE_11: counts hold until channel reset or load (tx: either buffer).
// RULE_12: rx count writable when loaded; writing when idle also loads.
// RULE_13: buffer unloads once start plus count exceeds end.
// RULE_14: end or count writes re-run the comparison and may unload early.
// RULE_15: unloads set flags tx b 12, tx a 11, rx b 10, rx a 9.
// RULE_16: mode field 0 off, 1 uart, 2 spi, 3 i2c.
// RULE_17: uart mode only exists on the first serial controller.
// RULE_18: uart parity error sets bit 14, framing error bit 13.
// RULE_19: i2c nack bit 8, start/stop done 7, tx done 6, rx done 5.
// RULE_20: underrun 4, overrun 3, tx idle 2, tx free 1, rx data 0.
// RULE_21: errored received byte records its offset as first error.
// RULE_22: on unload a pending buffer takes over at the next byte.
module spd_dma_top #(
  parameter int MEM_AW = 16,
  parameter bit IS_FIRST_CTRL = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [spd_pkg::REG_AW-1:0] reg_addr,
  input wire logic [spd_pkg::REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [spd_pkg::REG_DW-1:0] reg_rdata,
  output logic [MEM_AW-1:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  input wire logic [7:0] mem_rdata,
  input wire logic tx_fifo_full,
  output logic tx_fifo_push,
  output logic [7:0] tx_fifo_data,
  input wire logic rx_fifo_valid,
  input wire logic [7:0] rx_fifo_data,
  input wire logic rx_fifo_parity_err,
  input wire logic rx_fifo_frame_err,
  output logic rx_fifo_pop,
  input wire logic parity_error_evt,
  input wire logic framing_error_evt,
  input wire logic nack_received_evt,
  input wire logic start_stop_done_evt,
  input wire logic i2c_transmit_done_evt,
  input wire logic i2c_receive_done_evt,
  input wire logic transmit_underrun_evt,
  input wire logic receive_overrun_evt,
  input wire logic transmitter_idle_evt,
  input wire logic transmit_space_free_evt,
  input wire logic receive_data_available_evt,
  output logic [1:0] controller_mode_field,
  output logic [14:0] serial_interrupt_pending_flags
);
  import spd_pkg::*;

  // ==========================================================
  // storage
  logic [MEM_AW-1:0] tx_beg [2];
  logic [MEM_AW-1:0] tx_end [2];
  logic [MEM_AW-1:0] rx_beg [2];
  logic [MEM_AW-1:0] rx_end [2];
  logic [MEM_AW-1:0] rx_cnt [2];
  logic [MEM_AW-1:0] rx_err [2];
  logic rx_err_vld [2];
  logic [MEM_AW-1:0] tx_shared_byte_count;
  spd_buf_e tx_st [2];
  spd_buf_e rx_st [2];
  logic tx_over [2];
  logic rx_over [2];
  logic tx_unload [2];
  logic rx_unload [2];
  logic tx_load [2];
  logic rx_load [2];
  logic rx_cnt_wr [2];
  logic tx_promote;
  logic rx_promote;

  // ==========================================================
  // register decode
  logic wr_ctrl;
  logic tx_channel_reset_bit;
  logic rx_channel_reset_bit;
  logic tx_buffer_load_bit [2];
  logic rx_buffer_load_bit [2];

  assign wr_ctrl = reg_wr && reg_addr == OFS_DMA_CTRL;
  assign tx_channel_reset_bit = wr_ctrl && reg_wdata[CTL_TX_RESET];
  assign rx_channel_reset_bit = wr_ctrl && reg_wdata[CTL_RX_RESET];
  assign tx_buffer_load_bit[0] = wr_ctrl && reg_wdata[CTL_TX_LOAD_A];
  assign tx_buffer_load_bit[1] = wr_ctrl && reg_wdata[CTL_TX_LOAD_B];
  assign rx_buffer_load_bit[0] = wr_ctrl && reg_wdata[CTL_RX_LOAD_A];
  assign rx_buffer_load_bit[1] = wr_ctrl && reg_wdata[CTL_RX_LOAD_B];
  assign rx_cnt_wr[0] = reg_wr && reg_addr == OFS_RX_CNT_A;
  assign rx_cnt_wr[1] = reg_wr && reg_addr == OFS_RX_CNT_B;

  // ==========================================================
  // unload comparison and loads, per buffer
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_buf
      // end byte inclusive: only strictly beyond end unloads
      assign tx_over[gi] = ({1'b0, tx_beg[gi]} + {1'b0, tx_shared_byte_count})
                           > {1'b0, tx_end[gi]}; // [RULE_05] [RULE_13] [RULE_08]
      assign rx_over[gi] = ({1'b0, rx_beg[gi]} + {1'b0, rx_cnt[gi]})
                           > {1'b0, rx_end[gi]}; // [RULE_05] [RULE_13] [RULE_14]
      assign tx_unload[gi] = tx_st[gi] == BUF_ACTIVE && tx_over[gi]; // [RULE_14]
      assign rx_unload[gi] = rx_st[gi] != BUF_IDLE && rx_over[gi]; // [RULE_14]
      assign tx_load[gi] = tx_buffer_load_bit[gi] && tx_st[gi] == BUF_IDLE;
      assign rx_load[gi] = (rx_buffer_load_bit[gi] || rx_cnt_wr[gi])
                           && rx_st[gi] == BUF_IDLE; // [RULE_12]
    end
  endgenerate

  spd_pingpong u_tx_pp (
    .clk_sys(clk_sys),
    .rst(rst),
    .chan_reset(tx_channel_reset_bit),
    .load_a(tx_load[0]),
    .load_b(tx_load[1]),
    .unload_a(tx_unload[0]),
    .unload_b(tx_unload[1]),
    .state_a(tx_st[0]),
    .state_b(tx_st[1]),
    .promote(tx_promote)
  );

  spd_pingpong u_rx_pp (
    .clk_sys(clk_sys),
    .rst(rst),
    .chan_reset(rx_channel_reset_bit),
    .load_a(rx_load[0]),
    .load_b(rx_load[1]),
    .unload_a(rx_unload[0]),
    .unload_b(rx_unload[1]),
    .state_a(rx_st[0]),
    .state_b(rx_st[1]),
    .promote(rx_promote)
  );

  // ==========================================================
  // transfer decision
  logic enabled;
  logic rx_sel;
  logic tx_sel;
  logic rx_go;
  logic tx_go;

  assign enabled = controller_mode_field != MODE_DISABLED;
  assign rx_sel = rx_st[1] == BUF_ACTIVE;
  assign tx_sel = tx_st[1] == BUF_ACTIVE;
  assign rx_go = enabled && rx_fifo_valid && !rx_fifo_pop
              && rx_st[rx_sel] == BUF_ACTIVE && !rx_over[rx_sel]; // [RULE_02]
  assign tx_go = enabled && !tx_fifo_full && !mem_re && !tx_fifo_push && !rx_go
              && tx_st[tx_sel] == BUF_ACTIVE && !tx_over[tx_sel]; // [RULE_02]

  // ==========================================================
  // memory port and fifo strobes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mem_addr <= '0;
      mem_wdata <= 8'h00;
      mem_we <= 1'b0;
      mem_re <= 1'b0;
      rx_fifo_pop <= 1'b0;
    end else begin
      mem_we <= rx_go;
      mem_re <= tx_go;
      rx_fifo_pop <= rx_go;
      if (rx_go) begin
        mem_addr <= MEM_AW'(rx_beg[rx_sel] + rx_cnt[rx_sel]);
        mem_wdata <= rx_fifo_data;
      end else if (tx_go) begin
        mem_addr <= MEM_AW'(tx_beg[tx_sel] + tx_shared_byte_count);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_fifo_push <= 1'b0;
      tx_fifo_data <= 8'h00;
    end else begin
      tx_fifo_push <= mem_re;
      if (mem_re) begin
        tx_fifo_data <= mem_rdata;
      end
    end
  end

  // ==========================================================
  // counts
  always_ff @(posedge clk_sys) begin
    if (rst || tx_channel_reset_bit) begin // [RULE_04]
      tx_shared_byte_count <= '0;
    end else if (tx_load[0] || tx_load[1] || tx_promote) begin // [RULE_11] [RULE_22]
      tx_shared_byte_count <= '0;
    end else if (tx_go) begin
      tx_shared_byte_count <= MEM_AW'(tx_shared_byte_count + 1'b1); // [RULE_09] [RULE_10]
    end
  end

  generate
    for (gi = 0; gi < 2; gi++) begin : g_rxcnt
      always_ff @(posedge clk_sys) begin
        if (rst || rx_channel_reset_bit) begin // [RULE_04]
          rx_cnt[gi] <= '0;
        end else if (rx_cnt_wr[gi]) begin // [RULE_12] [RULE_14]
          rx_cnt[gi] <= reg_wdata[MEM_AW-1:0];
        end else if (rx_load[gi]) begin // [RULE_11]
          rx_cnt[gi] <= '0;
        end else if (rx_go && rx_sel == 1'(gi)) begin
          rx_cnt[gi] <= MEM_AW'(rx_cnt[gi] + 1'b1); // [RULE_09] [RULE_10]
        end
      end

      always_ff @(posedge clk_sys) begin
        if (rst || rx_channel_reset_bit || rx_load[gi]) begin
          rx_err[gi] <= '0;
          rx_err_vld[gi] <= 1'b0;
        end else if (rx_go && rx_sel == 1'(gi) && !rx_err_vld[gi]
                     && (rx_fifo_parity_err || rx_fifo_frame_err)) begin // [RULE_21]
          rx_err[gi] <= rx_cnt[gi];
          rx_err_vld[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // ==========================================================
  // buffer address registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_beg[0] <= '0;
      tx_beg[1] <= '0;
      tx_end[0] <= '0;
      tx_end[1] <= '0;
      rx_beg[0] <= '0;
      rx_beg[1] <= '0;
      rx_end[0] <= '0;
      rx_end[1] <= '0;
    end else if (reg_wr) begin
      if (reg_addr == OFS_TX_BEG_A) begin
        tx_beg[0] <= reg_wdata[MEM_AW-1:0];
      end else if (reg_addr == OFS_TX_BEG_B) begin
        tx_beg[1] <= reg_wdata[MEM_AW-1:0];
      end else if (reg_addr == OFS_TX_END_A) begin
        tx_end[0] <= reg_wdata[MEM_AW-1:0]; // [RULE_08]
      end else if (reg_addr == OFS_TX_END_B) begin
        tx_end[1] <= reg_wdata[MEM_AW-1:0]; // [RULE_08]
      end else if (reg_addr == OFS_RX_BEG_A) begin
        rx_beg[0] <= reg_wdata[MEM_AW-1:0];
      end else if (reg_addr == OFS_RX_BEG_B) begin
        rx_beg[1] <= reg_wdata[MEM_AW-1:0];
      end else if (reg_addr == OFS_RX_END_A) begin
        rx_end[0] <= reg_wdata[MEM_AW-1:0]; // [RULE_08]
      end else if (reg_addr == OFS_RX_END_B) begin
        rx_end[1] <= reg_wdata[MEM_AW-1:0]; // [RULE_08]
      end
    end
  end

  // ==========================================================
  // mode register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      controller_mode_field <= MODE_RST;
    end else if (reg_wr && reg_addr == OFS_MODE) begin
      if (reg_wdata[1:0] != MODE_UART || IS_FIRST_CTRL) begin // [RULE_16] [RULE_17]
        controller_mode_field <= reg_wdata[1:0];
      end
    end
  end

  // ==========================================================
  // pending flags: write one clears, a new event wins
  logic [14:0] flag_set;
  logic [14:0] flag_clr;

  always_comb begin
    flag_set = 15'h0000;
    flag_set[FLG_PAR_ERR] = parity_error_evt; // [RULE_18]
    flag_set[FLG_FRM_ERR] = framing_error_evt; // [RULE_18]
    flag_set[FLG_TX_ULD_B] = tx_unload[1]; // [RULE_15]
    flag_set[FLG_TX_ULD_A] = tx_unload[0]; // [RULE_15]
    flag_set[FLG_RX_ULD_B] = rx_unload[1]; // [RULE_15]
    flag_set[FLG_RX_ULD_A] = rx_unload[0]; // [RULE_15]
    flag_set[FLG_NACK] = nack_received_evt; // [RULE_19]
    flag_set[FLG_CMD_DONE] = start_stop_done_evt; // [RULE_19]
    flag_set[FLG_I2C_TX_DONE] = i2c_transmit_done_evt; // [RULE_19]
    flag_set[FLG_I2C_RX_DONE] = i2c_receive_done_evt; // [RULE_19]
    flag_set[FLG_TX_UNDERRUN] = transmit_underrun_evt; // [RULE_20]
    flag_set[FLG_RX_OVERRUN] = receive_overrun_evt; // [RULE_20]
    flag_set[FLG_TX_IDLE] = transmitter_idle_evt; // [RULE_20]
    flag_set[FLG_TX_FREE] = transmit_space_free_evt; // [RULE_20]
    flag_set[FLG_RX_VALID] = receive_data_available_evt; // [RULE_20]
  end

  assign flag_clr = (reg_wr && reg_addr == OFS_FLAGS) ? reg_wdata[14:0] : 15'h0000;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      serial_interrupt_pending_flags <= FLAGS_RST;
    end else begin
      serial_interrupt_pending_flags <= (serial_interrupt_pending_flags & ~flag_clr)
                                        | flag_set;
    end
  end

  // ==========================================================
  // read port, data in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= 32'h00000000;
      if (reg_addr == OFS_FLAGS) begin
        reg_rdata[14:0] <= serial_interrupt_pending_flags;
      end else if (reg_addr == OFS_MODE) begin
        reg_rdata[1:0] <= controller_mode_field;
      end else if (reg_addr == OFS_TX_BEG_A) begin
        reg_rdata[MEM_AW-1:0] <= tx_beg[0];
      end else if (reg_addr == OFS_TX_BEG_B) begin
        reg_rdata[MEM_AW-1:0] <= tx_beg[1];
      end else if (reg_addr == OFS_TX_END_A) begin
        reg_rdata[MEM_AW-1:0] <= tx_end[0];
      end else if (reg_addr == OFS_TX_END_B) begin
        reg_rdata[MEM_AW-1:0] <= tx_end[1];
      end else if (reg_addr == OFS_RX_BEG_A) begin
        reg_rdata[MEM_AW-1:0] <= rx_beg[0];
      end else if (reg_addr == OFS_RX_BEG_B) begin
        reg_rdata[MEM_AW-1:0] <= rx_beg[1];
      end else if (reg_addr == OFS_RX_END_A) begin
        reg_rdata[MEM_AW-1:0] <= rx_end[0];
      end else if (reg_addr == OFS_RX_END_B) begin
        reg_rdata[MEM_AW-1:0] <= rx_end[1];
      end else if (reg_addr == OFS_TX_CNT) begin
        reg_rdata[MEM_AW-1:0] <= tx_shared_byte_count;
      end else if (reg_addr == OFS_RX_CNT_A) begin
        reg_rdata[MEM_AW-1:0] <= rx_cnt[0];
      end else if (reg_addr == OFS_RX_CNT_B) begin
        reg_rdata[MEM_AW-1:0] <= rx_cnt[1];
      end else if (reg_addr == OFS_RX_ERR_A) begin
        reg_rdata[MEM_AW-1:0] <= rx_err[0];
        reg_rdata[ERR_VALID_BIT] <= rx_err_vld[0];
      end else if (reg_addr == OFS_RX_ERR_B) begin
        reg_rdata[MEM_AW-1:0] <= rx_err[1];
        reg_rdata[ERR_VALID_BIT] <= rx_err_vld[1];
      end else if (reg_addr == OFS_DMA_STAT) begin
        reg_rdata[7:0] <= {rx_st[1], rx_st[0], tx_st[1], tx_st[0]};
      end
    end
  end

endmodule : spd_dma_top

/* spd_dma_props.sv */
`timescale 1ns/1ns
// ==========================================================
// dma checker
module spd_dma_props
  import spd_pkg::*;
#(
  parameter bit IS_FIRST_CTRL = 1'b1
) (
  input logic clk_sys,
  input logic rst,
  input logic [REG_AW-1:0] reg_addr,
  input logic [REG_DW-1:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [REG_DW-1:0] reg_rdata,
  input logic mem_we,
  input logic mem_re,
  input logic tx_fifo_full,
  input logic tx_fifo_push,
  input logic rx_fifo_valid,
  input logic rx_fifo_pop,
  input logic parity_error_evt,
  input logic framing_error_evt,
  input logic nack_received_evt,
  input logic start_stop_done_evt,
  input logic i2c_transmit_done_evt,
  input logic i2c_receive_done_evt,
  input logic transmit_underrun_evt,
  input logic receive_overrun_evt,
  input logic transmitter_idle_evt,
  input logic transmit_space_free_evt,
  input logic receive_data_available_evt,
  input logic [1:0] controller_mode_field,
  input logic [14:0] serial_interrupt_pending_flags
);
  logic [14:0] evts;
  assign evts = {parity_error_evt, framing_error_evt, 4'h0, nack_received_evt,
    start_stop_done_evt, i2c_transmit_done_evt, i2c_receive_done_evt, transmit_underrun_evt,
    receive_overrun_evt, transmitter_idle_evt, transmit_space_free_evt,
    receive_data_available_evt};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_tx_fetch;
    mem_re ##1 tx_fifo_push;
  endsequence
  a_tx_fetch_push: assert property (mem_re |-> s_tx_fetch)
    else $error("no push");
  a_tx_push_cause: assert property (tx_fifo_push |-> $past(mem_re))
    else $error("stray push");
  a_tx_not_full: assert property (mem_re |-> !$past(tx_fifo_full))
    else $error("fetch when full");
  a_rx_write_pop: assert property (mem_we |-> rx_fifo_pop && $past(rx_fifo_valid))
    else $error("bad rx write");
  a_rx_pop_gap: assert property (rx_fifo_pop |=> !rx_fifo_pop)
    else $error("pop twice");
  a_mode_gates_dma: assert property ((mem_we || mem_re) |-> $past(controller_mode_field) != MODE_DISABLED)
    else $error("dma while off");
  a_mode_write: assert property (reg_wr && reg_addr == OFS_MODE && reg_wdata[1:0] != MODE_UART
    |=> controller_mode_field == $past(reg_wdata[1:0]))
    else $error("mode not set");
  a_uart_first_only: assert property (reg_wr && reg_addr == OFS_MODE && reg_wdata[1:0] == MODE_UART
    |=> controller_mode_field == (IS_FIRST_CTRL ? MODE_UART : $past(controller_mode_field)))
    else $error("uart mode wrong");
  a_mode_readback: assert property (reg_rd && reg_addr == OFS_MODE
    |=> reg_rdata == {30'h0, $past(controller_mode_field)})
    else $error("bad mode read");
  a_flag_set: assert property ((|evts) |=> (serial_interrupt_pending_flags & $past(evts)) == $past(evts))
    else $error("flag not set");
  a_flag_clear: assert property (reg_wr && reg_addr == OFS_FLAGS && evts == 15'h0000
    |=> (serial_interrupt_pending_flags & $past(reg_wdata[14:0]) & 15'h61ff) == 15'h0000)
    else $error("flag not cleared");
endmodule : spd_dma_props

bind spd_dma_top spd_dma_props #(.IS_FIRST_CTRL(IS_FIRST_CTRL)) u_props (.*);

/* spd_far_model.sv */
`timescale 1ns/1ns
// ==========================================================
// ram and fifos
module spd_far_model (
  input logic clk_sys,
  input logic stall,
  input logic [15:0] mem_addr,
  input logic [7:0] mem_wdata,
  input logic mem_we,
  input logic mem_re,
  output logic [7:0] mem_rdata,
  output logic tx_fifo_full,
  input logic tx_fifo_push,
  input logic [7:0] tx_fifo_data,
  output logic rx_fifo_valid,
  output logic [7:0] rx_fifo_data,
  output logic rx_fifo_parity_err,
  output logic rx_fifo_frame_err,
  input logic rx_fifo_pop
);
  logic [7:0] ram [0:255];
  logic [7:0] tx_got [$];
  logic [9:0] rx_q [$];
  logic [9:0] head;
  initial begin
    rx_fifo_valid = 1'b0;
    head = 10'h000;
  end
  assign tx_fifo_full = stall;
  assign mem_rdata = mem_re ? ram[mem_addr[7:0]] : ~ram[mem_addr[7:0]];
  assign {rx_fifo_parity_err, rx_fifo_frame_err, rx_fifo_data} = head;
  always @(posedge clk_sys) begin
    if (mem_we) ram[mem_addr[7:0]] <= mem_wdata;
    if (tx_fifo_push) tx_got.push_back(tx_fifo_data);
    if (rx_fifo_pop && rx_q.size() > 0) void'(rx_q.pop_front());
    rx_fifo_valid <= rx_q.size() > 0;
    head <= (rx_q.size() > 0) ? rx_q[0] : ~head;
  end
endmodule : spd_far_model

/* tb.sv */
`timescale 1ns/1ns
module tb;
  import spd_pkg::*;
  logic clk_sys, rst, reg_wr, reg_rd, stall;
  logic [15:0] reg_addr, mem_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [7:0] mem_wdata, mem_rdata, tx_fifo_data, rx_fifo_data;
  logic mem_we, mem_re, tx_fifo_full, tx_fifo_push, rx_fifo_valid, rx_fifo_pop;
  logic rx_fifo_parity_err, rx_fifo_frame_err, rx_fifo_pop_unused;
  logic [10:0] evt;
  logic [1:0] controller_mode_field;
  logic [14:0] serial_interrupt_pending_flags;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  int flag_pos [11] = '{14, 13, 8, 7, 6, 5, 4, 3, 2, 1, 0};
  spd_dma_top DUT (.*, .parity_error_evt(evt[0]), .framing_error_evt(evt[1]),
    .nack_received_evt(evt[2]), .start_stop_done_evt(evt[3]), .i2c_transmit_done_evt(evt[4]),
    .i2c_receive_done_evt(evt[5]), .transmit_underrun_evt(evt[6]),
    .receive_overrun_evt(evt[7]), .transmitter_idle_evt(evt[8]),
    .transmit_space_free_evt(evt[9]), .receive_data_available_evt(evt[10]));
  spd_far_model far (.*);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ==========================================================
  // shared tasks
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : rd
  task automatic rchk(input string what, input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask : rchk
  task automatic poll(input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] d;
    rd(OFS_DMA_STAT, d);
    for (int i = 0; i < 100 && (d & mask) !== exp; i++) rd(OFS_DMA_STAT, d);
    chk("dma status", exp, d & mask);
  endtask : poll
  // ==========================================================
  // scenarios
  task automatic t_regs;
    rchk("flags reset", OFS_FLAGS, 32'h0);
    rchk("mode reset", OFS_MODE, 32'h0);
    rchk("unmapped", 16'hc8f0, 32'h0);
    for (int m = 0; m < 4; m++) begin
      wr(OFS_MODE, 32'(m));
      rchk("mode", OFS_MODE, 32'(m));
    end
    wr(OFS_MODE, {30'h0, MODE_SPI});
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_sys);
      evt <= 11'h001 << i;
      @(posedge clk_sys);
      evt <= 11'h000;
      rchk("flag set", OFS_FLAGS, 32'h1 << flag_pos[i]);
      wr(OFS_FLAGS, 32'h1 << flag_pos[i]);
      rchk("flag clear", OFS_FLAGS, 32'h0);
    end
  endtask : t_regs
  task automatic t_rx_pingpong;
    wr(OFS_DMA_CTRL, 32'h1 << CTL_RX_RESET);
    wr(OFS_RX_BEG_A, 32'h10);
    wr(OFS_RX_END_A, 32'h13);
    wr(OFS_RX_BEG_B, 32'h20);
    wr(OFS_RX_END_B, 32'h21);
    wr(OFS_DMA_CTRL, 32'h3);
    rchk("rx states", OFS_DMA_STAT, 32'h70);
    for (int i = 0; i < 6; i++) far.rx_q.push_back({i == 1, 1'b0, 8'ha0 + 8'(i)});
    poll(32'hf0, 32'h0);
    for (int i = 0; i < 6; i++) chk("rx ram", 32'ha0 + i, {24'h0, far.ram[i < 4 ? 16 + i : 28 + i]});
    chk("past end", 32'h5a, {24'h0, far.ram[20]});
    rchk("rx count a", OFS_RX_CNT_A, 32'h4);
    rchk("rx count b", OFS_RX_CNT_B, 32'h2);
    rchk("rx error a", OFS_RX_ERR_A, 32'h0001_0001);
    rchk("rx flags", OFS_FLAGS, 32'h600);
  endtask : t_rx_pingpong
  task automatic t_rx_writes;
    wr(OFS_FLAGS, 32'h7fff);
    wr(OFS_RX_BEG_A, 32'h30);
    wr(OFS_RX_END_A, 32'h31);
    wr(OFS_RX_CNT_A, 32'h1);
    rchk("rx load", OFS_DMA_STAT, 32'h30);
    far.rx_q.push_back(10'h0c1);
    poll(32'h30, 32'h0);
    chk("rx byte", 32'hc1, {24'h0, far.ram[8'h31]});
    rchk("rx count a", OFS_RX_CNT_A, 32'h2);
    wr(OFS_RX_BEG_B, 32'h40);
    wr(OFS_RX_END_B, 32'h4f);
    wr(OFS_DMA_CTRL, 32'h1 << CTL_RX_LOAD_B);
    wr(OFS_RX_END_B, 32'h3f);
    rchk("early unload", OFS_DMA_STAT, 32'h0);
    rchk("flags", OFS_FLAGS, 32'h600);
    wr(OFS_DMA_CTRL, 32'h1 << CTL_RX_RESET);
    rchk("rx cnt reset", OFS_RX_CNT_A, 32'h0);
  endtask : t_rx_writes
  task automatic t_tx_pingpong;
    wr(OFS_FLAGS, 32'h7fff);
    stall <= 1'b1;
    wr(OFS_TX_BEG_A, 32'h50);
    wr(OFS_TX_END_A, 32'h52);
    wr(OFS_TX_BEG_B, 32'h60);
    wr(OFS_TX_END_B, 32'h61);
    wr(OFS_DMA_CTRL, 32'hc);
    rchk("tx states", OFS_DMA_STAT, 32'h7);
    @(posedge clk_sys);
    stall <= 1'b0;
    poll(32'hf, 32'h0);
    chk("tx bytes", 32'h5, far.tx_got.size());
    for (int i = 0; i < 5; i++) chk("tx byte", 32'hb0 + i, {24'h0, far.tx_got[i]});
    rchk("tx count", OFS_TX_CNT, 32'h2);
    rchk("tx flags", OFS_FLAGS, 32'h1800);
    wr(OFS_DMA_CTRL, 32'h1 << CTL_TX_RESET);
    rchk("tx cnt reset", OFS_TX_CNT, 32'h0);
  endtask : t_tx_pingpong
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 32'h0;
    evt = 11'h000;
    stall = 1'b0;
    for (int i = 0; i < 5; i++) far.ram[i < 3 ? 80 + i : 93 + i] = 8'hb0 + 8'(i);
    far.ram[20] = 8'h5a;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_rx_pingpong();
    t_rx_writes();
    t_tx_pingpong();
    end_of_test();
  end
endmodule : tb
